// File: pkg/i2c_master_transmit_defs.svh
`ifndef I2C_MASTER_TRANSMIT_DEFS_SVH
`define I2C_MASTER_TRANSMIT_DEFS_SVH

// Default reload of the baud generator: one phase lasts this many clocks plus one
`define BAUD_RELOAD_DEFAULT 8'h09
// Bits per byte before the acknowledge slot
`define BITS_PER_BYTE 4'h8
// Last bit index shifted out of the byte
`define MSB_INDEX 3'h7
// Start hold time in ns and derived clock count at 50 ns period
`define START_HOLD_NS 4000
`define CLK_PERIOD_NS 50
`define START_HOLD_CYCLES ((`START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Direction bit value for master transmitter
`define DIR_WRITE 1'h0
// Synchroniser length for the sensed bus lines
`define SYNC_STAGES 3

`endif

// File: pkg/i2c_master_transmit_pkg.sv
package i2c_master_transmit_pkg;

    // Controller states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START_A,
        ST_START_HOLD,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_WAIT,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C,
        ST_RS_A,
        ST_RS_B
    } tx_state_t;

    // Status flags shown to software
    typedef struct packed {
        logic buffer_full_flag;
        logic serial_event_flag;
        logic ack_status_bit;
        logic write_collision_flag;
        logic busy;
    } tx_status_t;

    // Software requests
    typedef struct packed {
        logic start_request_bit;
        logic restart_request_bit;
        logic stop_request_bit;
    } tx_request_t;

endpackage : i2c_master_transmit_pkg

// File: verilog/i2c_master_transmit.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_master_transmit_defs.svh"

module i2c_master_transmit
    import i2c_master_transmit_pkg::*;
#(
    // Reload of 4 or more keeps the acknowledge sample inside the ninth high phase
    parameter logic [7:0] BAUD_RELOAD = `BAUD_RELOAD_DEFAULT,
    parameter int START_HOLD = `START_HOLD_CYCLES
) (
    input wire logic sys_clk_i, // System clock, 20 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic buf_write_i, // One-cycle write strobe of the byte buffer
    input wire logic [7:0] buf_data_i, // Byte written to the buffer
    input wire logic addr_byte_i, // Write carries a 7-bit address; bit 0 forced to write direction
    input wire logic [2:0] request_i, // Start, restart, stop request pulses
    input wire logic clear_event_i, // Clears the serial event flag
    input wire logic clear_collision_i, // Clears the write-collision flag
    input wire logic sda_i, // Sensed SDA level
    input wire logic scl_i, // Sensed SCL level (unused for stretching)
    output logic sda_o, // SDA output value, always low
    output logic sda_oe_o, // SDA drive enable, high pulls low
    output logic scl_o, // SCL output value, always low
    output logic scl_oe_o, // SCL drive enable, high pulls low
    output logic [7:0] tx_byte_buffer_o, // Last accepted buffer contents
    output tx_status_t status_o // Status flags
);

    tx_state_t state_reg, state_next;
    tx_request_t req;
    logic [7:0] tx_byte_buffer_reg, tx_shift_register_reg;
    logic [7:0] baud_cnt_reg;
    logic [15:0] hold_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic buffer_full_flag_reg, serial_event_flag_reg, ack_status_bit_reg, write_collision_flag_reg;
    logic sda_oe_reg, scl_oe_reg;
    logic [`SYNC_STAGES-1:0] sda_sync_reg;
    logic [`SYNC_STAGES-1:0] scl_sync_reg;
    logic sda_level_reg;
    logic busy_reg;

    // Busy means a byte or a bus condition is in progress
    function automatic logic is_busy(input tx_state_t st);
        return (st != ST_IDLE) && (st != ST_WAIT);
    endfunction : is_busy

    // Request vector unpacked into named bits
    assign req = tx_request_t'(request_i);

    // Decode of phase timing and buffer access
    wire baud_done = (baud_cnt_reg == 8'h00);
    wire hold_done = (hold_cnt_reg == 16'h0000);
    wire busy = is_busy(state_reg);
    wire busy_next = is_busy(state_next);
    wire write_ok = buf_write_i && !busy;
    wire write_lost = buf_write_i && busy;
    wire [7:0] load_byte = addr_byte_i ? {buf_data_i[7:1], `DIR_WRITE} : buf_data_i;
    wire last_data_bit = (bit_cnt_reg == {1'h0, `MSB_INDEX});
    wire ack_slot = (bit_cnt_reg == `BITS_PER_BYTE);
    wire phase_end = baud_done && (state_reg == ST_BIT_HIGH);

    // Three-stage sampling of the bus lines; SDA level settles when stages two and three agree
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_sync_reg <= '1;
            scl_sync_reg <= '1;
            sda_level_reg <= 1'h1;
        end else begin
            sda_sync_reg <= {sda_sync_reg[`SYNC_STAGES-2:0], sda_i};
            scl_sync_reg <= {scl_sync_reg[`SYNC_STAGES-2:0], scl_i};
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_level_reg <= sda_sync_reg[2];
            end
        end
    end

    // Next-state decision
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_WAIT: begin
                if (write_ok) begin
                    state_next = ST_BIT_LOW;
                end else if (req.start_request_bit) begin
                    state_next = ST_START_A;
                end else if (req.stop_request_bit) begin
                    state_next = ST_STOP_A;
                end else if (req.restart_request_bit) begin
                    state_next = ST_RS_A;
                end
            end
            ST_START_A: if (baud_done) state_next = ST_START_HOLD;
            ST_START_HOLD: if (hold_done) state_next = ST_WAIT;
            ST_BIT_LOW: if (baud_done) state_next = ST_BIT_HIGH;
            ST_BIT_HIGH: begin
                if (baud_done) begin
                    state_next = ack_slot ? ST_WAIT : ST_BIT_LOW;
                end
            end
            ST_STOP_A: if (baud_done) state_next = ST_STOP_B;
            ST_STOP_B: if (baud_done) state_next = ST_STOP_C;
            ST_STOP_C: if (baud_done) state_next = ST_IDLE;
            ST_RS_A: if (baud_done) state_next = ST_RS_B;
            ST_RS_B: if (baud_done) state_next = ST_START_A;
            default: state_next = ST_IDLE;
        endcase
    end

    // Baud generator reloads on every phase change and stalls while waiting
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            baud_cnt_reg <= `BAUD_RELOAD_DEFAULT;
            hold_cnt_reg <= 16'h0000;
        end else begin
            baud_cnt_reg <= (state_next != state_reg || !busy) ? BAUD_RELOAD : baud_cnt_reg - 8'h01;
            hold_cnt_reg <= (state_reg == ST_START_A) ? 16'(START_HOLD - 1) :
                (hold_done ? 16'h0000 : hold_cnt_reg - 16'h0001);
        end
    end

    // Controller state, shift register and bit count
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            tx_byte_buffer_reg <= 8'h00;
            tx_shift_register_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            if (write_ok) begin
                tx_byte_buffer_reg <= load_byte;
                tx_shift_register_reg <= load_byte;
                bit_cnt_reg <= 4'h0;
            end else if (phase_end && !ack_slot) begin
                tx_shift_register_reg <= {tx_shift_register_reg[6:0], 1'h0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // Flags: hardware sets win over software clears
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buffer_full_flag_reg <= 1'h0;
            serial_event_flag_reg <= 1'h0;
            ack_status_bit_reg <= 1'h0;
            write_collision_flag_reg <= 1'h0;
        end else begin
            if (write_ok) begin
                buffer_full_flag_reg <= 1'h1;
            end else if (phase_end && last_data_bit) begin
                buffer_full_flag_reg <= 1'h0;
            end
            // Synchronised SDA lags four clocks, so take it as the ninth high phase ends
            if (phase_end && ack_slot) begin
                ack_status_bit_reg <= sda_level_reg;
            end
            if ((phase_end && ack_slot) || (state_reg == ST_START_HOLD && hold_done)
                    || (state_reg == ST_STOP_C && baud_done)) begin
                serial_event_flag_reg <= 1'h1;
            end else if (clear_event_i) begin
                serial_event_flag_reg <= 1'h0;
            end
            if (write_lost) begin
                write_collision_flag_reg <= 1'h1;
            end else if (clear_collision_i) begin
                write_collision_flag_reg <= 1'h0;
            end
        end
    end

    // Line drivers: SDA changes only while SCL is low, except in the start and stop conditions
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_oe_reg <= 1'h0;
            scl_oe_reg <= 1'h0;
        end else begin
            case (state_next)
                ST_START_A, ST_START_HOLD: begin
                    sda_oe_reg <= 1'h1;
                    scl_oe_reg <= (state_next == ST_START_HOLD);
                end
                ST_BIT_LOW: begin
                    scl_oe_reg <= 1'h1;
                    sda_oe_reg <= (bit_cnt_reg == `BITS_PER_BYTE) ? 1'h0 :
                        (write_ok ? !load_byte[7] : !tx_shift_register_reg[7]);
                end
                ST_BIT_HIGH: scl_oe_reg <= 1'h0;
                ST_WAIT: begin
                    scl_oe_reg <= 1'h1;
                    sda_oe_reg <= 1'h0;
                end
                ST_STOP_A: begin
                    scl_oe_reg <= 1'h1;
                    sda_oe_reg <= 1'h1;
                end
                ST_STOP_B: scl_oe_reg <= 1'h0;
                ST_STOP_C: sda_oe_reg <= 1'h0;
                ST_RS_A: begin
                    scl_oe_reg <= 1'h1;
                    sda_oe_reg <= 1'h0;
                end
                ST_RS_B: scl_oe_reg <= 1'h0;
                default: begin
                    scl_oe_reg <= 1'h0;
                    sda_oe_reg <= 1'h0;
                end
            endcase
        end
    end

    // Outputs; drive value fixed low so lines are only pulled low or released
    assign sda_o = 1'h0;
    assign scl_o = 1'h0;
    assign sda_oe_o = sda_oe_reg;
    assign scl_oe_o = scl_oe_reg;
    assign tx_byte_buffer_o = tx_byte_buffer_reg;
    assign status_o = '{buffer_full_flag: buffer_full_flag_reg, serial_event_flag: serial_event_flag_reg,
        ack_status_bit: ack_status_bit_reg, write_collision_flag: write_collision_flag_reg, busy: busy_reg};

endmodule : i2c_master_transmit
`default_nettype wire

// File: tb/i2c_master_transmit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_transmit_checker
    import i2c_master_transmit_pkg::*;
#(
    parameter logic [7:0] BAUD_RELOAD = 8'h01
) (
    input wire logic sys_clk_i, // Clock
    input wire logic reset_n_i, // Reset, active low
    input wire logic buf_write_i, // Buffer write strobe
    input wire logic clear_collision_i, // Collision clear
    input wire logic sda_o, // SDA value
    input wire logic sda_oe_o, // SDA pull enable
    input wire logic scl_o, // SCL value
    input wire logic scl_oe_o, // SCL pull enable
    input wire logic [7:0] tx_byte_buffer_o, // Buffer contents
    input wire tx_status_t status_o // Flags
);
    logic [7:0] hi_cnt_reg; // Cycles with SCL released
    // Length of the current released SCL phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) hi_cnt_reg <= 8'h00;
        else hi_cnt_reg <= scl_oe_o ? 8'h00 : hi_cnt_reg + 8'h01;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_open_drain; sda_o == 1'h0 && scl_o == 1'h0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_bf_set; buf_write_i && !status_o.busy |=> status_o.buffer_full_flag; endproperty
    a_bf_set: assert property (p_bf_set) else $error("buffer full not set");
    property p_collide; buf_write_i && status_o.busy |=> status_o.write_collision_flag; endproperty
    a_collide: assert property (p_collide) else $error("collision not flagged");
    property p_keep_buf; buf_write_i && status_o.busy |=> $stable(tx_byte_buffer_o); endproperty
    a_keep_buf: assert property (p_keep_buf) else $error("buffer overwritten");
    property p_write_collision_flag_hold;
        status_o.write_collision_flag && !clear_collision_i |=> status_o.write_collision_flag;
    endproperty
    a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision cleared alone");
    property p_high_len;
        $rose(scl_oe_o) && status_o.buffer_full_flag && $past(status_o.buffer_full_flag)
            |-> hi_cnt_reg == BAUD_RELOAD + 8'h01;
    endproperty
    a_high_len: assert property (p_high_len) else $error("SCL high phase length");
    property p_sda_still;
        status_o.buffer_full_flag && !scl_oe_o && !$past(scl_oe_o) |-> $stable(sda_oe_o);
    endproperty
    a_sda_still: assert property (p_sda_still) else $error("SDA moved with SCL high");
    property p_ack_free; $fell(status_o.buffer_full_flag) |-> ##[0:2] !sda_oe_o; endproperty
    a_ack_free: assert property (p_ack_free) else $error("SDA kept in ack slot");
    property p_ack_event;
        $fell(status_o.buffer_full_flag) |-> ##[1:40] status_o.serial_event_flag;
    endproperty
    a_ack_event: assert property (p_ack_event) else $error("no event after byte");
    // Main scenarios seen
    c_event: cover property ($rose(status_o.serial_event_flag));
    c_write_collision_flag: cover property ($rose(status_o.write_collision_flag));
    c_nack: cover property ($rose(status_o.ack_status_bit));
endmodule : i2c_master_transmit_checker
bind i2c_master_transmit i2c_master_transmit_checker #(.BAUD_RELOAD(BAUD_RELOAD)) u_chk (
    .sys_clk_i, .reset_n_i, .buf_write_i, .clear_collision_i, .sda_o, .sda_oe_o,
    .scl_o, .scl_oe_o, .tx_byte_buffer_o, .status_o);
`default_nettype wire

// File: tb/i2c_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
    input wire logic scl_i, // SCL wire level
    input wire logic sda_i, // SDA wire level
    input wire logic ack_en_i, // Acknowledge the coming byte
    output logic sda_oe_o, // High pulls SDA low
    output logic [7:0] rx_byte_o // Last byte received
);
    int bit_cnt = 0;
    // Start or restart opens a new frame
    always @(negedge sda_i) if (scl_i) bit_cnt = 0;
    // Shift bits in while SCL rises
    always @(posedge scl_i) begin
        if (bit_cnt < 8) rx_byte_o = {rx_byte_o[6:0], sda_i};
        bit_cnt = bit_cnt + 1;
    end
    // Pull SDA only during the ninth bit
    always @(negedge scl_i) begin
        sda_oe_o = (bit_cnt == 8) && ack_en_i;
        if (bit_cnt == 9) bit_cnt = 0;
    end
    initial sda_oe_o = 1'h0;
    initial rx_byte_o = 8'h00;
endmodule : i2c_slave_model
`default_nettype wire

// File: tb/i2c_master_transmit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_transmit_tb
    import i2c_master_transmit_pkg::*;
;
    typedef struct packed {logic is_byte; logic ack; logic [7:0] data; logic [1:0] lines;} note_t;
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    logic buf_write = 1'h0;
    logic [7:0] buf_data = 8'h00;
    logic addr_byte = 1'h0;
    tx_request_t req = '0;
    logic clear_event = 1'h0;
    logic clear_collision = 1'h0;
    logic ack_en = 1'h1;
    logic sda_oe, scl_oe, slave_oe, ev_q;
    logic [7:0] tx_buf, rx_byte;
    logic [31:0] rnd;
    tx_status_t status;
    wire logic sda = !(sda_oe || slave_oe); // Pull-up on released line
    wire logic scl = !scl_oe;
    note_t notes[$];
    note_t got;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 55090;
    always #25 sys_clk = ~sys_clk;
    i2c_master_transmit #(.BAUD_RELOAD(8'h05), .START_HOLD(2)) u_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .buf_write_i(buf_write), .buf_data_i(buf_data),
        .addr_byte_i(addr_byte), .request_i(req), .clear_event_i(clear_event),
        .clear_collision_i(clear_collision), .sda_i(sda), .scl_i(scl), .sda_o(), .sda_oe_o(sda_oe),
        .scl_o(), .scl_oe_o(scl_oe), .tx_byte_buffer_o(tx_buf), .status_o(status));
    i2c_slave_model u_slave (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .sda_oe_o(slave_oe),
        .rx_byte_o(rx_byte));
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic g, input logic e);
        cmp_byte({7'h00, g}, {7'h00, e});
    endtask : cmp_bit
    task automatic print_verdict();
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // Wait for completion, then acknowledge it
    task automatic wait_event();
        for (int n = 0; n < 500 && status.serial_event_flag !== 1'h1; n++) @(posedge sys_clk);
        cmp_bit(status.serial_event_flag, 1'h1);
        @(posedge sys_clk);
        clear_event <= 1'h1;
        @(posedge sys_clk);
        clear_event <= 1'h0;
        @(posedge sys_clk);
    endtask : wait_event
    task automatic request(input logic [2:0] r, input logic [1:0] lines);
        notes.push_back(note_t'{1'h0, 1'h0, 8'h00, lines});
        req <= r;
        @(posedge sys_clk);
        req <= '0;
        wait_event();
    endtask : request
    // Send one byte and try a colliding write while it shifts
    task automatic send(input logic [7:0] d, input logic is_addr, input logic ack);
        logic [7:0] e;
        e = is_addr ? {d[7:1], 1'h0} : d;
        notes.push_back(note_t'{1'h1, !ack, e, 2'h1});
        ack_en <= ack;
        buf_write <= 1'h1;
        buf_data <= d;
        addr_byte <= is_addr;
        @(posedge sys_clk);
        buf_write <= 1'h0;
        @(posedge sys_clk);
        cmp_bit(status.buffer_full_flag, 1'h1);
        cmp_bit(status.busy, 1'h1);
        buf_write <= 1'h1;
        buf_data <= ~d;
        @(posedge sys_clk);
        buf_write <= 1'h0;
        @(posedge sys_clk);
        cmp_bit(status.write_collision_flag, 1'h1);
        cmp_byte(tx_buf, e);
        clear_collision <= 1'h1;
        @(posedge sys_clk);
        clear_collision <= 1'h0;
        wait_event();
    endtask : send
    // Match each completion event against the oldest note; cut hangs short
    always @(posedge sys_clk) begin
        ev_q <= status.serial_event_flag;
        cycles++;
        if (status.serial_event_flag === 1'h1 && ev_q !== 1'h1) begin
            got = notes.pop_front();
            cmp_byte({6'h00, scl, sda}, {6'h00, got.lines});
            cmp_bit(status.busy, 1'h0);
            if (got.is_byte) begin
                cmp_bit(status.ack_status_bit, got.ack);
                cmp_byte(rx_byte, got.data);
            end
        end
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        notes.push_back(note_t'{1'h0, 1'h0, 8'h00, 2'h1});
        req <= 3'h4;
        @(posedge sys_clk);
        req <= '0;
        buf_write <= 1'h1;
        buf_data <= 8'h5A;
        @(posedge sys_clk);
        buf_write <= 1'h0;
        @(posedge sys_clk);
        cmp_bit(status.write_collision_flag, 1'h1);
        cmp_byte(tx_buf, 8'h00);
        clear_collision <= 1'h1;
        @(posedge sys_clk);
        clear_collision <= 1'h0;
        wait_event();
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            if (i == 5) request(3'h2, 2'h1);
            send(rnd[7:0], i == 0 || i == 5, i[0] || i == 0);
        end
        request(3'h1, 2'h3);
        print_verdict();
    end
endmodule : i2c_master_transmit_tb
`default_nettype wire
